// ### verilog/ctsio_pkg.sv
package ctsio_pkg;
    // Register byte offsets on the APB slave.
    localparam logic [7:0] OFF_CTRL   = 8'h00;
    localparam logic [7:0] OFF_SHUT   = 8'h04;
    localparam logic [7:0] OFF_EXPO   = 8'h08;
    localparam logic [7:0] OFF_READ   = 8'h0C;
    localparam logic [7:0] OFF_DAC    = 8'h10;
    localparam logic [7:0] OFF_DIR    = 8'h14;
    localparam logic [7:0] OFF_OUT    = 8'h18;
    localparam logic [7:0] OFF_IN     = 8'h1C;
    localparam logic [7:0] OFF_STATUS = 8'h20;
    // Field positions.
    localparam int CTRL_PWR_BIT  = 0;
    localparam int DAC2_LSB      = 8;
    localparam int ST_STATE_LSB  = 0;
    localparam int ST_COUNT_LSB  = 16;
    // Widths.
    localparam int DAC_W  = 8;
    localparam int TTL_W  = 8;
    localparam int CNT_W  = 32;
    // Values after reset, in pclk cycles for the phase lengths.
    localparam logic [31:0] RST_SHUT = 32'h0000_0064;
    localparam logic [31:0] RST_EXPO = 32'h0000_03E8;
    localparam logic [31:0] RST_READ = 32'h0000_03E8;
    localparam logic [7:0]  RST_DAC  = 8'h00;
    localparam logic [7:0]  RST_DIR  = 8'h00;
    // Acquisition sequencer states.
    typedef enum logic [1:0] {SEQ_IDLE, SEQ_SHUT, SEQ_EXPO, SEQ_READ} ctsio_seq_t;
endpackage

// ### verilog/ctsio_trig_if.sv
`timescale 1ns/1ps
// Carries the cleaned trigger from the edge detector to the sequencer.
interface ctsio_trig_if;
    logic trig_pulse; // One-cycle start request.
    logic trig_level; // Synchronised trigger level.
    modport det (output trig_pulse, output trig_level);
    modport use_side (input trig_pulse, input trig_level);
endinterface

// ### verilog/ctsio_trig_edge.sv
`timescale 1ns/1ps
// Synchronises trigger and polarity pins and emits one pulse per selected edge.
module ctsio_trig_edge (
    input  wire logic   pclk,    // System clock.
    input  wire logic   presetn, // Asynchronous reset, active low.
    input  wire logic   trig_in, // Raw trigger pin.
    input  wire logic   pol_in,  // Raw polarity select pin, high means rising.
    ctsio_trig_if.det   tif      // Cleaned trigger towards the sequencer.
);
    typedef struct packed {
        logic s1_t;  // First stage, read only by s2_t.
        logic s2_t;  // Second stage of trigger.
        logic s3_t;  // Delayed copy for edge compare.
        logic s1_p;  // First stage of polarity.
        logic s2_p;  // Settled polarity.
        logic pulse; // Registered start pulse.
    } ctsio_edge_t;

    ctsio_edge_t st;      // Current state.
    ctsio_edge_t next_st; // Next state.

    // Edge decision looks only at settled stages, never at the first ones.
    always_comb
    begin
        next_st      = st;
        next_st.s1_t = trig_in;
        next_st.s2_t = st.s1_t;
        next_st.s3_t = st.s2_t;
        next_st.s1_p = pol_in;
        next_st.s2_p = st.s1_p;
        if (st.s2_p)
        begin
            next_st.pulse = st.s2_t && !st.s3_t;
        end
        else
        begin
            next_st.pulse = !st.s2_t && st.s3_t;
        end
    end

    // An unconnected pin floats high outside, so polarity stages reset high; trigger stages reset low.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            st <= '{s1_t: 1'b0, s2_t: 1'b0, s3_t: 1'b0, s1_p: 1'b1, s2_p: 1'b1, pulse: 1'b0};
        end
        else
        begin
            st <= next_st;
        end
    end

    assign tif.trig_pulse = st.pulse;
    assign tif.trig_level = st.s2_t;

    property p_rise;
        @(posedge pclk) disable iff (!presetn)
        (st.s2_p && st.s2_t && !st.s3_t) |=> st.pulse;
    endproperty
    a_rise: assert property (p_rise) else $error("Rising edge missed.");

    property p_fall;
        @(posedge pclk) disable iff (!presetn)
        (!st.s2_p && !st.s2_t && st.s3_t) |=> st.pulse;
    endproperty
    a_fall: assert property (p_fall) else $error("Falling edge missed.");

    property p_single;
        @(posedge pclk) disable iff (!presetn)
        st.pulse |=> !st.pulse;
    endproperty
    a_single: assert property (p_single) else $error("Pulse longer than one cycle.");

    property p_cause;
        @(posedge pclk) disable iff (!presetn)
        st.pulse |-> ($past(st.s2_t) != $past(st.s3_t));
    endproperty
    a_cause: assert property (p_cause) else $error("Pulse without an edge.");

    c_edge: cover property (@(posedge pclk) disable iff (!presetn) st.pulse);
endmodule

// ### verilog/ctsio_top.sv
`timescale 1ns/1ps
// How it works
// - Polarity high: rising trigger edge starts.
// - Polarity low: falling trigger edge starts.
// - Readout output high during data transfer.
// - Exposing output high while integrating.
// - Power output high while power on.
// - Two analog outputs, 8-bit values each.
// - Four 2-bit ports, per-bit direction.
// - Shutter high during compensation and exposure.
module ctsio_top (
    input  wire logic        pclk,          // System clock, 100 MHz.
    input  wire logic        presetn,       // Asynchronous reset, active low.
    input  wire logic        psel,          // APB select.
    input  wire logic        penable,       // APB access phase.
    input  wire logic        pwrite,        // APB direction, high for write.
    input  wire logic [7:0]  paddr,         // APB byte address.
    input  wire logic [31:0] pwdata,        // APB write data.
    output logic      [31:0] prdata,        // APB read data.
    output logic             pready,        // APB ready.
    output logic             pslverr,       // APB error on unmapped address.
    input  wire logic        trig_in,       // Trigger pin.
    input  wire logic        trig_pol,      // Polarity select pin, high is rising.
    output logic             frame_readout, // High while data is transferred.
    output logic             exposing,      // High while the sensor integrates.
    output logic             power_status,  // High while camera power is on.
    output logic             shutter_out,   // External shutter timing.
    output logic      [7:0]  dac1,          // First analog output setting.
    output logic      [7:0]  dac2,          // Second analog output setting.
    input  wire logic [7:0]  ttl_in,        // Port pins in, bit 2p+b is port p bit b.
    output logic      [7:0]  ttl_out,       // Port pins out.
    output logic      [7:0]  ttl_oe         // Port pin drive enables, high drives.
);
    typedef struct packed {
        ctsio_pkg::ctsio_seq_t seq;  // Sequencer state.
        logic [31:0] cnt;            // Cycles left in the phase.
        logic        pwr;            // Power switch from software.
        logic [31:0] shut_len;       // Compensation length in cycles.
        logic [31:0] expo_len;       // Exposure length in cycles.
        logic [31:0] read_len;       // Readout length in cycles.
        logic [7:0]  dac_a;          // First analog value.
        logic [7:0]  dac_b;          // Second analog value.
        logic [7:0]  dir;            // Direction, one means output.
        logic [7:0]  dout;           // Output levels.
        logic [7:0]  din;            // Sampled input levels.
        logic [15:0] trig_cnt;       // Accepted triggers.
        logic        rdy;            // APB ready.
        logic        err;            // APB error.
        logic [31:0] rdata;          // APB read data.
        logic        o_read;         // Readout output.
        logic        o_expo;         // Exposing output.
        logic        o_shut;         // Shutter output.
    } ctsio_top_t;

    ctsio_top_t st;      // Current state.
    ctsio_top_t next_st; // Next state.

    ctsio_trig_if tif ();

    // Edge detector for the trigger pin.
    ctsio_trig_edge u_edge (
        .pclk    (pclk),
        .presetn (presetn),
        .trig_in (trig_in),
        .pol_in  (trig_pol),
        .tif     (tif.det)
    );

    // Phase length minus one; a zero length still lasts one cycle.
    function automatic logic [31:0] len_m1(input logic [31:0] v);
        len_m1 = (v == 32'h0000_0000) ? 32'h0000_0000 : v - 32'h0000_0001;
    endfunction

    logic setup_ph;  // APB setup cycle.
    logic wr_done;   // Write taking effect at this edge.
    assign setup_ph = psel && !penable;
    assign wr_done  = psel && penable && st.rdy && pwrite;

    // Bus decode, register writes and the acquisition sequencer.
    always_comb
    begin
        next_st     = st;
        next_st.din = ttl_in;
        next_st.rdy = 1'b0;
        next_st.err = 1'b0;
        // Answer is prepared in setup so ready and data come straight from flops.
        if (setup_ph)
        begin
            next_st.rdy   = 1'b1;
            next_st.rdata = 32'h0000_0000;
            unique case (paddr)
                ctsio_pkg::OFF_CTRL:   next_st.rdata[ctsio_pkg::CTRL_PWR_BIT] = st.pwr;
                ctsio_pkg::OFF_SHUT:   next_st.rdata = st.shut_len;
                ctsio_pkg::OFF_EXPO:   next_st.rdata = st.expo_len;
                ctsio_pkg::OFF_READ:   next_st.rdata = st.read_len;
                ctsio_pkg::OFF_DAC:    next_st.rdata[15:0] = {st.dac_b, st.dac_a};
                ctsio_pkg::OFF_DIR:    next_st.rdata[7:0] = st.dir;
                ctsio_pkg::OFF_OUT:    next_st.rdata[7:0] = st.dout;
                ctsio_pkg::OFF_IN:     next_st.rdata[7:0] = st.din;
                ctsio_pkg::OFF_STATUS: next_st.rdata = {st.trig_cnt, 14'h0000, st.seq};
                default:               next_st.err = 1'b1;
            endcase
        end
        // Writes land only at the access edge; unmapped writes are dropped.
        if (wr_done)
        begin
            unique case (paddr)
                ctsio_pkg::OFF_CTRL: next_st.pwr = pwdata[ctsio_pkg::CTRL_PWR_BIT];
                ctsio_pkg::OFF_SHUT: next_st.shut_len = pwdata;
                ctsio_pkg::OFF_EXPO: next_st.expo_len = pwdata;
                ctsio_pkg::OFF_READ: next_st.read_len = pwdata;
                ctsio_pkg::OFF_DAC:
                begin
                    next_st.dac_a = pwdata[ctsio_pkg::DAC_W-1:0];
                    next_st.dac_b = pwdata[ctsio_pkg::DAC2_LSB +: ctsio_pkg::DAC_W];
                end
                ctsio_pkg::OFF_DIR:  next_st.dir = pwdata[ctsio_pkg::TTL_W-1:0];
                ctsio_pkg::OFF_OUT:  next_st.dout = pwdata[ctsio_pkg::TTL_W-1:0];
                default:             next_st.dout = st.dout;
            endcase
        end
        // Sequencer: a trigger while busy is ignored, so frames never overlap.
        unique case (st.seq)
            ctsio_pkg::SEQ_IDLE:
            begin
                if (tif.trig_pulse && st.pwr)
                begin
                    next_st.seq      = ctsio_pkg::SEQ_SHUT;
                    next_st.cnt      = len_m1(st.shut_len);
                    next_st.trig_cnt = st.trig_cnt + 16'h0001;
                end
            end
            ctsio_pkg::SEQ_SHUT:
            begin
                if (st.cnt == 32'h0000_0000)
                begin
                    next_st.seq = ctsio_pkg::SEQ_EXPO;
                    next_st.cnt = len_m1(st.expo_len);
                end
                else
                begin
                    next_st.cnt = st.cnt - 32'h0000_0001;
                end
            end
            ctsio_pkg::SEQ_EXPO:
            begin
                if (st.cnt == 32'h0000_0000)
                begin
                    next_st.seq = ctsio_pkg::SEQ_READ;
                    next_st.cnt = len_m1(st.read_len);
                end
                else
                begin
                    next_st.cnt = st.cnt - 32'h0000_0001;
                end
            end
            ctsio_pkg::SEQ_READ:
            begin
                if (st.cnt == 32'h0000_0000)
                begin
                    next_st.seq = ctsio_pkg::SEQ_IDLE;
                end
                else
                begin
                    next_st.cnt = st.cnt - 32'h0000_0001;
                end
            end
        endcase
        // Switching power off aborts any frame at once.
        if (!next_st.pwr)
        begin
            next_st.seq = ctsio_pkg::SEQ_IDLE;
        end
        // Outputs follow the next state so pins change with the state itself.
        next_st.o_read = (next_st.seq == ctsio_pkg::SEQ_READ);
        next_st.o_expo = (next_st.seq == ctsio_pkg::SEQ_EXPO);
        next_st.o_shut = (next_st.seq == ctsio_pkg::SEQ_SHUT) ||
                         (next_st.seq == ctsio_pkg::SEQ_EXPO);
    end

    // State register.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            st          <= '0;
            st.seq      <= ctsio_pkg::SEQ_IDLE;
            st.shut_len <= ctsio_pkg::RST_SHUT;
            st.expo_len <= ctsio_pkg::RST_EXPO;
            st.read_len <= ctsio_pkg::RST_READ;
            st.dac_a    <= ctsio_pkg::RST_DAC;
            st.dac_b    <= ctsio_pkg::RST_DAC;
            st.dir      <= ctsio_pkg::RST_DIR;
        end
        else
        begin
            st <= next_st;
        end
    end

    assign prdata        = st.rdata;
    assign pready        = st.rdy;
    assign pslverr       = st.err;
    assign frame_readout = st.o_read;
    assign exposing      = st.o_expo;
    assign power_status  = st.pwr;
    assign shutter_out   = st.o_shut;
    assign dac1          = st.dac_a;
    assign dac2          = st.dac_b;
    assign ttl_out       = st.dout;
    assign ttl_oe        = st.dir;

    property p_start;
        @(posedge pclk) disable iff (!presetn)
        (st.seq == ctsio_pkg::SEQ_IDLE && tif.trig_pulse && st.pwr && next_st.pwr)
            |=> shutter_out && !exposing && !frame_readout;
    endproperty
    a_start: assert property (p_start) else $error("Trigger did not open shutter.");

    property p_expo_order;
        @(posedge pclk) disable iff (!presetn)
        $rose(exposing) |-> $past(shutter_out) && shutter_out;
    endproperty
    a_expo_order: assert property (p_expo_order) else $error("Exposure not after comp.");

    property p_read_order;
        @(posedge pclk) disable iff (!presetn)
        $rose(frame_readout) |-> $past(exposing) && !shutter_out;
    endproperty
    a_read_order: assert property (p_read_order) else $error("Readout not after exposure.");

    property p_shut_cover;
        @(posedge pclk) disable iff (!presetn)
        exposing |-> shutter_out;
    endproperty
    a_shut_cover: assert property (p_shut_cover) else $error("Shutter low during exposure.");

    property p_power;
        @(posedge pclk) disable iff (!presetn)
        (wr_done && paddr == ctsio_pkg::OFF_CTRL)
            |=> power_status == $past(pwdata[ctsio_pkg::CTRL_PWR_BIT]);
    endproperty
    a_power: assert property (p_power) else $error("Power status not updated.");

    property p_power_off;
        @(posedge pclk) disable iff (!presetn)
        !power_status |-> !exposing && !frame_readout && !shutter_out;
    endproperty
    a_power_off: assert property (p_power_off) else $error("Activity with power off.");

    property p_dac;
        @(posedge pclk) disable iff (!presetn)
        (wr_done && paddr == ctsio_pkg::OFF_DAC)
            |=> dac1 == $past(pwdata[7:0]) && dac2 == $past(pwdata[15:8]);
    endproperty
    a_dac: assert property (p_dac) else $error("Analog values not updated.");

    property p_dir;
        @(posedge pclk) disable iff (!presetn)
        (wr_done && paddr == ctsio_pkg::OFF_DIR) |=> ttl_oe == $past(pwdata[7:0]);
    endproperty
    a_dir: assert property (p_dir) else $error("Port direction not updated.");

    property p_apb;
        @(posedge pclk) disable iff (!presetn)
        setup_ph |=> pready ##1 !pready;
    endproperty
    a_apb: assert property (p_apb) else $error("Ready not one cycle after setup.");

    c_frame: cover property (@(posedge pclk) disable iff (!presetn) $fell(frame_readout));
    c_expo:  cover property (@(posedge pclk) disable iff (!presetn) $rose(exposing));
    c_err:   cover property (@(posedge pclk) disable iff (!presetn) pslverr);
endmodule

// ### sim/ctsio_trig_src.sv
`timescale 1ns/1ps
// Trigger source model: parks the pin at the idle level of the chosen polarity.
module ctsio_trig_src (
    input  wire logic pclk,     // System clock, used to time pin changes.
    output logic      trig_in,  // Trigger pin.
    output logic      trig_pol  // Polarity select pin.
);
    // The pin starts idle low, as a rising-edge source would hold it.
    initial
    begin
        trig_pol = 1'b1;
        trig_in  = 1'b0;
    end
    // Polarity and idle level change together, so no request is implied.
    task automatic set_pol(input logic pol);
        @(posedge pclk);
        trig_pol <= pol;
        trig_in  <= ~pol;
    endtask
    // One request; the active level is held for the given number of cycles.
    task automatic pulse(input int width);
        @(posedge pclk);
        trig_in <= trig_pol;
        repeat (width) @(posedge pclk);
        trig_in <= ~trig_pol;
    endtask
endmodule

// ### sim/camera_trigger_status_io_tb.sv
`timescale 1ns/1ps
// Self-checking bench: register table first, then trigger frames.
module camera_trigger_status_io_tb;
    localparam int SH = 3; // Compensation length written by the bench.
    localparam int EX = 5; // Exposure length written by the bench.
    localparam int RL = 4; // Readout length written by the bench.
    typedef struct {
        logic        wr;
        logic [7:0]  addr;
        logic [31:0] data;
        logic [31:0] exp;
        logic        err;
    } ctsio_row_t;
    logic        pclk;
    logic        presetn;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        trig_in;
    logic        trig_pol;
    logic        frame_readout;
    logic        exposing;
    logic        power_status;
    logic        shutter_out;
    logic [7:0]  dac1;
    logic [7:0]  dac2;
    logic [7:0]  ttl_in;
    logic [7:0]  ttl_out;
    logic [7:0]  ttl_oe;
    logic [31:0] rd;         // Read data of the last transfer.
    logic        err;        // Error response of the last transfer.
    int          cs;         // Cycles with the shutter output high.
    int          ce;         // Cycles with the exposing output high.
    int          cr;         // Cycles with the readout output high.
    int          bad;        // Cycles where the outputs overlap wrongly or exposure ends without readout.
    int          fail_count;
    int          num_checks;
    // Reserved bits of DAC and DIR are written as ones so that reads prove they stay zero.
    ctsio_row_t rows [23] = '{
        '{1'b0, ctsio_pkg::OFF_SHUT, 32'h0, ctsio_pkg::RST_SHUT, 1'b0},
        '{1'b0, ctsio_pkg::OFF_EXPO, 32'h0, ctsio_pkg::RST_EXPO, 1'b0},
        '{1'b0, ctsio_pkg::OFF_READ, 32'h0, ctsio_pkg::RST_READ, 1'b0},
        '{1'b0, ctsio_pkg::OFF_DAC, 32'h0, 32'h0, 1'b0},
        '{1'b0, ctsio_pkg::OFF_DIR, 32'h0, 32'h0, 1'b0},
        '{1'b0, ctsio_pkg::OFF_CTRL, 32'h0, 32'h0, 1'b0},
        '{1'b1, ctsio_pkg::OFF_CTRL, 32'h1, 32'h0, 1'b0},
        '{1'b0, ctsio_pkg::OFF_CTRL, 32'h0, 32'h1, 1'b0},
        '{1'b1, ctsio_pkg::OFF_DAC, 32'hFFFF_A5FF, 32'h0, 1'b0},
        '{1'b0, ctsio_pkg::OFF_DAC, 32'h0, 32'h0000_A5FF, 1'b0},
        '{1'b1, ctsio_pkg::OFF_DIR, 32'hFFFF_FF0F, 32'h0, 1'b0},
        '{1'b0, ctsio_pkg::OFF_DIR, 32'h0, 32'h0000_000F, 1'b0},
        '{1'b1, ctsio_pkg::OFF_OUT, 32'h0000_005A, 32'h0, 1'b0},
        '{1'b0, ctsio_pkg::OFF_OUT, 32'h0, 32'h0000_005A, 1'b0},
        '{1'b0, ctsio_pkg::OFF_IN, 32'h0, 32'h0000_00C3, 1'b0},
        '{1'b1, ctsio_pkg::OFF_IN, 32'h0, 32'h0, 1'b0},
        '{1'b0, ctsio_pkg::OFF_IN, 32'h0, 32'h0000_00C3, 1'b0},
        '{1'b1, 8'h24, 32'h1, 32'h0, 1'b1},
        '{1'b0, 8'h24, 32'h0, 32'h0, 1'b1},
        '{1'b1, ctsio_pkg::OFF_SHUT, SH, 32'h0, 1'b0},
        '{1'b1, ctsio_pkg::OFF_EXPO, EX, 32'h0, 1'b0},
        '{1'b1, ctsio_pkg::OFF_READ, RL, 32'h0, 1'b0},
        '{1'b0, ctsio_pkg::OFF_STATUS, 32'h0, 32'h0, 1'b0}
    };
    // Free-running 100 MHz clock.
    initial pclk = 1'b0;
    always #5 pclk = ~pclk;
    ctsio_top uut (
        .pclk          (pclk),
        .presetn       (presetn),
        .psel          (psel),
        .penable       (penable),
        .pwrite        (pwrite),
        .paddr         (paddr),
        .pwdata        (pwdata),
        .prdata        (prdata),
        .pready        (pready),
        .pslverr       (pslverr),
        .trig_in       (trig_in),
        .trig_pol      (trig_pol),
        .frame_readout (frame_readout),
        .exposing      (exposing),
        .power_status  (power_status),
        .shutter_out   (shutter_out),
        .dac1          (dac1),
        .dac2          (dac2),
        .ttl_in        (ttl_in),
        .ttl_out       (ttl_out),
        .ttl_oe        (ttl_oe)
    );
    ctsio_trig_src src (
        .pclk     (pclk),
        .trig_in  (trig_in),
        .trig_pol (trig_pol)
    );
    // Prints the verdict and ends the run; every exit comes through here.
    task automatic test_done;
        if (fail_count == 0 && num_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    // Compares a register or port value.
    task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp)
        begin
            fail_count++;
            $display("CHECK FAILED %0t value %h expected %h", $time, got, exp);
        end
    endtask
    // Compares a cycle count.
    task automatic chk_count(input int got, input int exp);
        num_checks++;
        if (got != exp)
        begin
            fail_count++;
            $display("CHECK FAILED %0t count %0d expected %0d", $time, got, exp);
        end
    endtask
    // One APB transfer; the request is held until pready is seen high or 16 cycles pass.
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do
        begin
            @(posedge pclk);
            n++;
        end
        while (pready !== 1'b1 && n < 16);
        rd      = prdata;
        err     = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        // A slave that never answers would otherwise hang the run.
        if (pready !== 1'b1)
        begin
            fail_count++;
            test_done();
        end
    endtask
    // Counts high cycles of the shutter, exposing and readout outputs over a fixed window.
    task automatic frame(input int cycles);
        logic prev_e;
        cs = 0;
        ce = 0;
        cr = 0;
        bad = 0;
        prev_e = 1'b0;
        repeat (cycles)
        begin
            @(posedge pclk);
            cs += int'(shutter_out === 1'b1);
            ce += int'(exposing === 1'b1);
            cr += int'(frame_readout === 1'b1);
            bad += int'(exposing === 1'b1 && shutter_out !== 1'b1);
            bad += int'(exposing === 1'b1 && frame_readout === 1'b1);
            bad += int'(prev_e === 1'b1 && exposing !== 1'b1 && frame_readout !== 1'b1);
            prev_e = exposing;
        end
    endtask
    // Expects n whole frames in the last window.
    task automatic chk_frame(input int n);
        chk_count(cs, n * (SH + EX));
        chk_count(ce, n * EX);
        chk_count(cr, n * RL);
        chk_count(bad, 0);
    endtask
    // Main sequence.
    initial
    begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        ttl_in = 8'hC3;
        fail_count = 0;
        num_checks = 0;
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        chk_word({28'h0, frame_readout, exposing, power_status, shutter_out}, 32'h0);
        foreach (rows[i])
        begin
            apb(rows[i].wr, rows[i].addr, rows[i].data);
            if (!rows[i].wr)
                chk_word(rd, rows[i].exp);
            chk_word({31'h0, err}, {31'h0, rows[i].err});
        end
        chk_word({ttl_oe, ttl_out, dac2, dac1}, 32'h0F5A_A5FF);
        chk_word({31'h0, power_status}, 32'h1);
        // New pin levels must show up in the input register, whatever the direction bits.
        ttl_in <= 8'h3C;
        apb(1'b0, ctsio_pkg::OFF_IN, 32'h0);
        chk_word(rd, 32'h0000_003C);
        // Rising edge starts a frame; the late falling edge must not.
        fork
            src.pulse(40);
            frame(60);
        join
        chk_frame(1);
        // Polarity swap alone starts nothing; the falling edge then does.
        src.set_pol(1'b0);
        fork
            src.pulse(40);
            frame(60);
        join
        chk_frame(1);
        // A second request while busy is dropped.
        fork
            begin
                src.pulse(2);
                repeat (3) @(posedge pclk);
                src.pulse(2);
            end
            frame(60);
        join
        chk_frame(1);
        // With power off no trigger is taken.
        src.set_pol(1'b1);
        apb(1'b1, ctsio_pkg::OFF_CTRL, 32'h0);
        @(posedge pclk);
        chk_word({31'h0, power_status}, 32'h0);
        fork
            src.pulse(40);
            frame(60);
        join
        chk_frame(0);
        apb(1'b0, ctsio_pkg::OFF_STATUS, 32'h0);
        chk_word(rd, 32'h0003_0000);
        // A second reset in mid-run clears the analog settings.
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        chk_word({16'h0, dac2, dac1}, 32'h0);
        presetn <= 1'b1;
        // Right after the release the bus answers and the compensation length is back at reset.
        apb(1'b0, ctsio_pkg::OFF_SHUT, 32'h0);
        chk_word(rd, ctsio_pkg::RST_SHUT);
        chk_word({28'h0, frame_readout, exposing, power_status, shutter_out}, 32'h0);
        test_done();
    end
endmodule
